// ==== shared/dwu_pkg.sv ====
// Purpose: constants shared by the converter waveform update control block
// Assumes: APB slave with 32-bit data, one word per register
// Notes: offsets are byte addresses; UI counts clock cycles, UC counts updates and BC counts repeats
package dwu_pkg;
    // ==========================================================
    // bus and register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_DATA0 = 8'h08;
    localparam logic [7:0] OFF_DATA1 = 8'h0C;
    localparam logic [7:0] OFF_FIFO = 8'h10;
    localparam logic [7:0] OFF_CMD = 8'h14;
    localparam logic [7:0] OFF_UI = 8'h18;
    localparam logic [7:0] OFF_UC = 8'h1C;
    localparam logic [7:0] OFF_BC = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_OUT0 = 8'h28;
    localparam logic [7:0] OFF_OUT1 = 8'h2C;
    // ==========================================================
    // output_config_reg fields, channel 1 sits CFG_STRIDE above channel 0
    localparam int CFG_TIMED = 0;
    localparam int CFG_BIPOLAR = 1;
    localparam int CFG_EXTERNAL_REFERENCE_INPUT = 2;
    localparam int CFG_REGLITCH = 3;
    localparam int CFG_STRIDE = 4;
    // control fields
    localparam int CTL_WAVE0 = 0;
    localparam int CTL_WAVE1 = 1;
    localparam int CTL_RETX = 2;
    // command strobes
    localparam int CMD_UPD0 = 0;
    localparam int CMD_UPD1 = 1;
    localparam int CMD_START = 2;
    localparam int CMD_STOP = 3;
    localparam int CMD_CLR = 4;
    // status fields
    localparam int ST_FULL = 0;
    localparam int ST_HALF = 1;
    localparam int ST_EMPTY = 2;
    localparam int ST_BUSY = 3;
    localparam int ST_CNT_LSB = 16;
    // ==========================================================
    // widths and reset values
    localparam int CNT_W = 24;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [23:0] LOAD_RST = 24'h00_0001;
    localparam int DEF_CODE_W = 16;
    localparam int DEF_FIFO_DEPTH = 2048;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_FETCH0 = 4'b0010,
        S_FETCH1 = 4'b0100,
        S_WAIT = 4'b1000
    } dwu_state_e;
endpackage

// ==== design/dwu_control.sv ====
// Purpose: two double-buffered converter channels with waveform timing engine
// Assumes: single clock, APB register access, FIFO depth 0 means virtual FIFO
// Notes: one wait state on every APB access
`timescale 1ns/10ps
module dwu_control #(
    parameter int CODE_W = dwu_pkg::DEF_CODE_W,
    parameter int FIFO_DEPTH = dwu_pkg::DEF_FIFO_DEPTH,
    parameter bit EXTERNAL_REFERENCE_INPUT_OK = 1'b1
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dwu_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [CODE_W-1:0] chan0Code,
    output logic [CODE_W-1:0] chan1Code,
    output logic chan0_update_strobe_n,
    output logic chan1_update_strobe_n,
    output logic [1:0] chanBipolar,
    output logic [1:0] chanExtRef,
    output logic [1:0] chanReglitch,
    output logic fifoFull,
    output logic fifoHalf,
    output logic fifoEmpty,
    output logic retransmitPulse
);
    import dwu_pkg::*;

    localparam bit VIRT = (FIFO_DEPTH == 0);
    localparam int MEM_D = VIRT ? 1 : FIFO_DEPTH;
    localparam int PW = (MEM_D > 1) ? $clog2(MEM_D) : 1;
    localparam logic [PW:0] FULL_CNT = (PW+1)'(MEM_D);
    localparam logic [PW:0] HALF_CNT = (PW+1)'(MEM_D / 2);

    logic [7:0] cfgReg;
    logic [2:0] ctrlReg;
    logic [CNT_W-1:0] uiLoadReg, ucLoadReg, bcLoadReg;
    logic [CNT_W-1:0] uiCnt_reg, ucCnt_reg, bcCnt_reg;
    logic [CODE_W-1:0] st0Reg, st1Reg;
    logic [CODE_W-1:0] mem [MEM_D];
    logic [PW-1:0] wrPtr_reg, rdPtr_reg;
    logic [PW:0] cnt_reg, loadCnt_reg;
    logic vFull_reg;
    dwu_state_e state_reg;
    logic [31:0] rdMux;
    logic addrOk;

    // ==========================================================
    // APB decode
    wire logic access = psel & penable;
    wire logic wrEn = access & pready & pwrite;
    wire logic wrFifo = wrEn & (paddr == OFF_FIFO);
    wire logic wrCmd = wrEn & (paddr == OFF_CMD);
    wire logic wrD0 = wrEn & (paddr == OFF_DATA0);
    wire logic wrD1 = wrEn & (paddr == OFF_DATA1);
    wire logic cmdClr = wrCmd & pwdata[CMD_CLR];
    wire logic timed0 = cfgReg[CFG_TIMED];
    wire logic timed1 = cfgReg[CFG_STRIDE + CFG_TIMED];
    wire logic wave0 = ctrlReg[CTL_WAVE0];
    wire logic wave1 = ctrlReg[CTL_WAVE1];

    always_comb begin
        addrOk = 1'b1;
        rdMux = 32'h0000_0000;
        case (paddr)
            OFF_CFG: rdMux = {24'h00_0000, cfgReg};
            OFF_CTRL: rdMux = {29'h0000_0000, ctrlReg};
            OFF_UI: rdMux = {8'h00, uiLoadReg};
            OFF_UC: rdMux = {8'h00, ucLoadReg};
            OFF_BC: rdMux = {8'h00, bcLoadReg};
            OFF_STATUS: begin
                rdMux[ST_CNT_LSB +: PW+1] = cnt_reg;
                rdMux[ST_BUSY] = (state_reg != S_IDLE);
                rdMux[ST_EMPTY] = fifoEmpty;
                rdMux[ST_HALF] = fifoHalf;
                rdMux[ST_FULL] = fifoFull;
            end
            OFF_OUT0: rdMux[CODE_W-1:0] = chan0Code;
            OFF_OUT1: rdMux[CODE_W-1:0] = chan1Code;
            OFF_DATA0, OFF_DATA1, OFF_FIFO, OFF_CMD: rdMux = 32'h0000_0000;
            default: addrOk = 1'b0;
        endcase
    end

    // answer one cycle into the access phase so every bus output is a flop
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access & ~pready;
            pslverr <= access & ~pready & ~addrOk;
            prdata <= (access & ~pready & ~pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfgReg <= CFG_RST;
            ctrlReg <= 3'b000;
            uiLoadReg <= LOAD_RST;
            ucLoadReg <= LOAD_RST;
            bcLoadReg <= LOAD_RST;
        end else if (wrEn) begin
            case (paddr)
                OFF_CFG: cfgReg <= pwdata[7:0];
                OFF_CTRL: ctrlReg <= pwdata[2:0];
                OFF_UI: uiLoadReg <= pwdata[CNT_W-1:0];
                OFF_UC: ucLoadReg <= pwdata[CNT_W-1:0];
                OFF_BC: bcLoadReg <= pwdata[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // timing engine
    wire logic startCmd = wrCmd & pwdata[CMD_START];
    wire logic stopCmd = wrCmd & (pwdata[CMD_STOP] | pwdata[CMD_CLR]);
    wire logic updEv = (state_reg == S_WAIT) && (uiCnt_reg <= 24'h00_0001);
    wire logic lastUc = (ucCnt_reg <= 24'h00_0001);
    wire logic lastBc = (bcCnt_reg <= 24'h00_0001);
    wire logic need0 = (state_reg == S_FETCH0) & wave0;
    wire logic need1 = (state_reg == S_FETCH1) & wave1;
    wire logic need = need0 | need1;
    // virtual FIFO: the host write itself is the sample
    wire logic avail = VIRT ? wrFifo : (cnt_reg != '0);
    wire logic take = need & avail;
    wire logic [CODE_W-1:0] sample = VIRT ? pwdata[CODE_W-1:0] : mem[rdPtr_reg];
    wire logic retx = !VIRT && ctrlReg[CTL_RETX] && need && (cnt_reg == '0)
        && (loadCnt_reg != '0);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= S_IDLE;
        end else if (stopCmd) begin
            state_reg <= S_IDLE;
        end else begin
            case (state_reg)
                S_IDLE: if (startCmd) state_reg <= S_FETCH0;
                S_FETCH0: if (!wave0 || take) state_reg <= S_FETCH1;
                S_FETCH1: if (!wave1 || take) state_reg <= S_WAIT;
                S_WAIT: begin
                    if (updEv) begin
                        state_reg <= (lastUc && lastBc) ? S_IDLE : S_FETCH0;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            uiCnt_reg <= '0;
            ucCnt_reg <= '0;
            bcCnt_reg <= '0;
        end else if (state_reg == S_IDLE && startCmd) begin
            uiCnt_reg <= uiLoadReg;
            ucCnt_reg <= ucLoadReg;
            bcCnt_reg <= bcLoadReg;
        end else if (state_reg == S_WAIT) begin
            if (updEv) begin
                uiCnt_reg <= uiLoadReg;
                if (lastUc) begin
                    ucCnt_reg <= ucLoadReg;
                    bcCnt_reg <= bcCnt_reg - 24'h00_0001;
                end else begin
                    ucCnt_reg <= ucCnt_reg - 24'h00_0001;
                end
            end else begin
                uiCnt_reg <= uiCnt_reg - 24'h00_0001;
            end
        end
    end

    // ==========================================================
    // output FIFO; a push while full is dropped
    wire logic push = !VIRT && wrFifo && (cnt_reg != FULL_CNT);
    wire logic pop = !VIRT && take;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr_reg] <= pwdata[CODE_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            cnt_reg <= '0;
            loadCnt_reg <= '0;
        end else if (cmdClr) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            cnt_reg <= '0;
            loadCnt_reg <= '0;
        end else if (retx) begin
            // replay from the first stored word; a write in the same cycle is dropped
            rdPtr_reg <= '0;
            cnt_reg <= loadCnt_reg;
        end else begin
            if (push) begin
                wrPtr_reg <= (wrPtr_reg == PW'(MEM_D - 1)) ? '0 : wrPtr_reg + 1'b1;
                if (loadCnt_reg != FULL_CNT) loadCnt_reg <= loadCnt_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= (rdPtr_reg == PW'(MEM_D - 1)) ? '0 : rdPtr_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            vFull_reg <= 1'b1;
        end else if (take) begin
            vFull_reg <= 1'b1;
        end else if (need) begin
            vFull_reg <= 1'b0;
        end else begin
            vFull_reg <= 1'b1;
        end
    end

    // half and empty carry no meaning for the virtual FIFO
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fifoFull <= VIRT;
            fifoHalf <= 1'b0;
            fifoEmpty <= 1'b1;
            retransmitPulse <= 1'b0;
        end else begin
            fifoFull <= VIRT ? vFull_reg : (cnt_reg == FULL_CNT);
            fifoHalf <= !VIRT && (cnt_reg >= HALF_CNT) && (cnt_reg != '0);
            fifoEmpty <= VIRT ? 1'b1 : (cnt_reg == '0);
            retransmitPulse <= retx;
        end
    end

    // ==========================================================
    // channel buffers; a fetch in the same cycle beats a direct write
    wire logic fill0 = need0 & take;
    wire logic fill1 = need1 & take;
    wire logic upd0 = (wrCmd & pwdata[CMD_UPD0]) | (updEv & wave0);
    wire logic upd1 = (wrCmd & pwdata[CMD_UPD1]) | (updEv & wave1);
    wire logic [CODE_W-1:0] st0Next = fill0 ? sample : pwdata[CODE_W-1:0];
    wire logic [CODE_W-1:0] st1Next = fill1 ? sample : pwdata[CODE_W-1:0];

    // zero code is zero volts in both straight binary and two's complement
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st0Reg <= '0;
            st1Reg <= '0;
        end else begin
            if (fill0 || wrD0) st0Reg <= st0Next;
            if (fill1 || wrD1) st1Reg <= st1Next;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            chan0Code <= '0;
            chan1Code <= '0;
        end else begin
            if (!timed0 && (fill0 || wrD0)) begin
                chan0Code <= st0Next;
            end else if (timed0 && upd0) begin
                chan0Code <= st0Reg;
            end
            if (!timed1 && (fill1 || wrD1)) begin
                chan1Code <= st1Next;
            end else if (timed1 && upd1) begin
                chan1Code <= st1Reg;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            chan0_update_strobe_n <= 1'b1;
            chan1_update_strobe_n <= 1'b1;
            chanBipolar <= 2'b00;
            chanExtRef <= 2'b00;
            chanReglitch <= 2'b00;
        end else begin
            chan0_update_strobe_n <= ~upd0;
            chan1_update_strobe_n <= ~upd1;
            chanBipolar <= {cfgReg[CFG_STRIDE+CFG_BIPOLAR], cfgReg[CFG_BIPOLAR]};
            chanReglitch <= {cfgReg[CFG_STRIDE+CFG_REGLITCH], cfgReg[CFG_REGLITCH]};
            chanExtRef <= EXTERNAL_REFERENCE_INPUT_OK ?
                {cfgReg[CFG_STRIDE+CFG_EXTERNAL_REFERENCE_INPUT], cfgReg[CFG_EXTERNAL_REFERENCE_INPUT]} : 2'b00;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence sStrobe0;
        upd0 && timed0 ##1 (!chan0_update_strobe_n && chan0Code == $past(st0Reg));
    endsequence
    property pStrobe0;
        upd0 && timed0 |-> sStrobe0;
    endproperty

    a_imm_output: assert property (wrD0 && !timed0 && !fill0 |=>
        chan0Code == $past(pwdata[CODE_W-1:0])) else $error("immediate write missed output");
    a_timed_hold: assert property (wrD0 && timed0 && !upd0 |=>
        $stable(chan0Code)) else $error("timed write moved output");
    a_strobe_load: assert property (pStrobe0) else $error("strobe did not load");
    a_fifo_bound: assert property (cnt_reg <= FULL_CNT)
        else $error("fifo count over depth");
    a_empty_wait: assert property (need0 && !VIRT && cnt_reg == '0 && !retx
        && !stopCmd && !wrD0 |=> state_reg == S_FETCH0 && $stable(st0Reg))
        else $error("fetch from empty fifo");
    a_ui_reload: assert property (updEv && !stopCmd |=> uiCnt_reg == $past(uiLoadReg))
        else $error("interval not reloaded");
    a_uc_count: assert property (updEv && !lastUc && !stopCmd
        |=> ucCnt_reg == $past(ucCnt_reg) - 24'h00_0001) else $error("update count wrong");
    a_seq_end: assert property (updEv && lastUc && lastBc && !stopCmd
        |=> state_reg == S_IDLE) else $error("sequence did not end");
    a_bc_dec: assert property (updEv && lastUc && !lastBc && !stopCmd
        |=> bcCnt_reg == $past(bcCnt_reg) - 24'h00_0001 && state_reg == S_FETCH0)
        else $error("repeat count wrong");
    a_fetch_load: assert property (fill0 |=> st0Reg == $past(sample))
        else $error("sample not fetched");
    a_retx_restore: assert property (retx && !cmdClr |=>
        cnt_reg == $past(loadCnt_reg) && rdPtr_reg == '0 ##1 $fell(retransmitPulse))
        else $error("retransmit did not restore");
endmodule

// ==== bench/dwu_apb_host.sv ====
// Purpose: APB host model that writes registers and the output FIFO
// Assumes: one clock, the slave ends every transfer with pready
// Notes: released address and data lines carry the inverse of the last value
`timescale 1ns/10ps
module dwu_apb_host (
    input wire logic ref_clk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic fifoFull,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [dwu_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata
);
    import dwu_pkg::*;
    int timeouts = 0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // ==========================================================
    // one transfer: setup, access held until pready is sampled high
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        q = prdata;
        err = pslverr;
        if (n >= 64) timeouts++;
        psel <= 1'b0;
        penable <= 1'b0;
        // stale values would hide a slave that samples outside the transfer
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    // ==========================================================
    // paced by the full flag only; half and empty are not consulted
    task automatic push(input logic [31:0] d);
        logic [31:0] q;
        logic e;
        int n;
        n = 0;
        while (fifoFull !== 1'b0 && n < 4000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 4000) timeouts++;
        xfer(1'b1, OFF_FIFO, d, q, e);
    endtask
endmodule

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench for the converter waveform update control
// Assumes: 512-word true FIFO, 16-bit codes, external reference allowed
// Notes: strobes are counted continuously, scenarios compare count differences
`timescale 1ns/10ps
module tb_top;
    import dwu_pkg::*;
    localparam int DEPTH = 512;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} dwu_row_s;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, fifoFull, fifoHalf, fifoEmpty;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] chan0Code, chan1Code;
    logic chan0_update_strobe_n, chan1_update_strobe_n, retransmitPulse;
    logic [1:0] chanBipolar, chanExtRef, chanReglitch;
    int errorCnt = 0;
    int cmpCount = 0;
    int st0 = 0;
    int st1 = 0;
    int stRx = 0;
    dwu_row_s rows [7] = '{
        '{OFF_CFG, 32'h0000_00E5, 32'h0000_00E5, 1'b0},
        '{OFF_CTRL, 32'h0000_0007, 32'h0000_0007, 1'b0},
        '{OFF_UI, 32'hFFFF_FFFF, 32'h00FF_FFFF, 1'b0},
        '{OFF_UC, 32'h0012_3456, 32'h0012_3456, 1'b0},
        '{OFF_BC, 32'hAB00_0002, 32'h0000_0002, 1'b0},
        '{OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0004, 1'b0},
        '{8'h30, 32'h0000_0001, 32'h0000_0000, 1'b1}
    };
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (chan0_update_strobe_n === 1'b0) st0++;
        if (chan1_update_strobe_n === 1'b0) st1++;
        if (retransmitPulse === 1'b1) stRx++;
    end
    dwu_control #(.CODE_W(16), .FIFO_DEPTH(DEPTH), .EXTERNAL_REFERENCE_INPUT_OK(1'b1)) u_dwu_control (
        .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan0Code(chan0Code), .chan1Code(chan1Code),
        .chan0_update_strobe_n(chan0_update_strobe_n),
        .chan1_update_strobe_n(chan1_update_strobe_n), .chanBipolar(chanBipolar),
        .chanExtRef(chanExtRef), .chanReglitch(chanReglitch), .fifoFull(fifoFull),
        .fifoHalf(fifoHalf), .fifoEmpty(fifoEmpty), .retransmitPulse(retransmitPulse));
    dwu_apb_host u_dwu_apb_host (
        .ref_clk(ref_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .fifoFull(fifoFull), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    // ==========================================================
    // shared tasks
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        u_dwu_apb_host.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        u_dwu_apb_host.xfer(1'b0, a, 32'h0000_0000, q, e);
        check32(q, exp);
    endtask
    task automatic codes(input logic [15:0] c0, input logic [15:0] c1);
        @(negedge ref_clk);
        check32({16'h0000, chan0Code}, {16'h0000, c0});
        check32({16'h0000, chan1Code}, {16'h0000, c1});
    endtask
    task automatic check_reset();
        @(negedge ref_clk);
        check32({16'h0000, chan0Code | chan1Code}, 32'h0000_0000);
        check32({24'h00_0000, chanBipolar, chanExtRef, chanReglitch, 2'b00}, 32'h0000_0000);
        check32({28'h000_0000, chan0_update_strobe_n, chan1_update_strobe_n, fifoFull, fifoEmpty},
                32'h0000_000D);
        rd(OFF_UI, 32'h0000_0001);
        rd(OFF_CTRL, 32'h0000_0000);
        rd(OFF_STATUS, 32'h0000_0004);
    endtask
    task automatic report_and_stop();
        errorCnt += u_dwu_apb_host.timeouts;
        $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========================================================
    // hang guard, roughly fifteen times the expected run
    initial begin
        #200_000;
        errorCnt++;
        report_and_stop();
    end
    initial begin
        logic [31:0] q;
        logic e;
        int s0, s1, rx;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        check_reset();
        foreach (rows[i]) begin
            u_dwu_apb_host.xfer(1'b1, rows[i].a, rows[i].d, q, e);
            check32({31'h0, e}, {31'h0, rows[i].e});
            u_dwu_apb_host.xfer(1'b0, rows[i].a, 32'h0000_0000, q, e);
            check32({31'h0, e}, {31'h0, rows[i].e});
            if (!rows[i].e) check32(q, rows[i].r);
        end
        check32({26'h0, chanBipolar, chanExtRef, chanReglitch}, 32'h0000_002E);
        // second reset in mid-run, after every load register was written
        arst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        check_reset();
        s0 = st0;
        wr(OFF_DATA0, 32'h0000_1234);
        codes(16'h1234, 16'h0000);
        check32(32'(st0 - s0), 32'h0000_0000);
        // waveform with a stall: six of eight samples present at start
        wr(OFF_CFG, 32'h0000_0011);
        wr(OFF_CTRL, 32'h0000_0003);
        wr(OFF_UI, 32'h0000_0003);
        wr(OFF_UC, 32'h0000_0002);
        wr(OFF_BC, 32'h0000_0002);
        for (int i = 0; i < 6; i++) u_dwu_apb_host.push(32'h0000_1000 + i);
        s0 = st0;
        s1 = st1;
        wr(OFF_CMD, 32'h0000_0001 << CMD_START);
        repeat (100) @(posedge ref_clk);
        check32(32'(st0 - s0), 32'h0000_0003);
        check32(32'(st1 - s1), 32'h0000_0003);
        rd(OFF_STATUS, 32'h0000_000C);
        for (int i = 6; i < 8; i++) u_dwu_apb_host.push(32'h0000_1000 + i);
        repeat (100) @(posedge ref_clk);
        check32(32'(st0 - s0), 32'h0000_0004);
        check32(32'(st1 - s1), 32'h0000_0004);
        codes(16'h1006, 16'h1007);
        rd(OFF_STATUS, 32'h0000_0004);
        // timed direct writes wait for the software strobe
        wr(OFF_DATA0, 32'h0000_BEEF);
        wr(OFF_DATA1, 32'h0000_5A5A);
        codes(16'h1006, 16'h1007);
        s0 = st0;
        s1 = st1;
        wr(OFF_CMD, 32'h0000_0003);
        codes(16'hBEEF, 16'h5A5A);
        // the strobe stands in the cycle after the write edge
        @(negedge ref_clk);
        check32(32'(st0 - s0 + st1 - s1), 32'h0000_0002);
        // replay the stored eight words without new writes
        wr(OFF_CTRL, 32'h0000_0007);
        s0 = st0;
        rx = stRx;
        wr(OFF_CMD, 32'h0000_0001 << CMD_START);
        repeat (100) @(posedge ref_clk);
        check32(32'(st0 - s0), 32'h0000_0004);
        check32(32'(stRx - rx), 32'h0000_0001);
        codes(16'h1006, 16'h1007);
        // fill to the limit, one dropped write, then clear
        wr(OFF_CTRL, 32'h0000_0000);
        // a stop right after start leaves the engine idle long before its natural end
        wr(OFF_CMD, 32'h0000_0001 << CMD_START);
        wr(OFF_CMD, 32'h0000_0001 << CMD_STOP);
        rd(OFF_STATUS, 32'h0000_0004);
        wr(OFF_CMD, 32'h0000_0001 << CMD_CLR);
        for (int i = 0; i < DEPTH; i++) begin
            u_dwu_apb_host.push(i);
            if (i == DEPTH / 2 - 2 || i == DEPTH / 2 - 1) begin
                // flags follow the count one edge later
                repeat (2) @(negedge ref_clk);
                check32({31'h0, fifoHalf}, 32'(i == DEPTH / 2 - 1));
            end
        end
        repeat (2) @(negedge ref_clk);
        check32({31'h0, fifoFull}, 32'h0000_0001);
        wr(OFF_FIFO, 32'h0000_FFFF);
        rd(OFF_STATUS, (32'(DEPTH) << ST_CNT_LSB) | 32'h0000_0003);
        wr(OFF_CMD, 32'h0000_0001 << CMD_CLR);
        rd(OFF_STATUS, 32'h0000_0004);
        report_and_stop();
    end
endmodule
